// ### bench/opc_optic_model.sv
// optical front end: led on the transmit pin, comparator on receive
// assumes the bench commands the light that reaches the receiver
`timescale 1ns/1ns
`default_nettype none

module opc_optic_model (
  input  wire logic optical_transmit_pin_out,
  input  wire logic optical_transmit_pin_oe_n,
  input  wire logic optical_receive_pin_out,
  input  wire logic optical_receive_pin_oe_n,
  input  wire logic light,
  output var  logic optical_receive_pin_in,
  output var  logic glow
);
  // an undriven led is dark, it never keeps the last level
  assign glow = !optical_transmit_pin_oe_n && optical_transmit_pin_out;
  // device drive wins the receive wire, else the comparator
  assign optical_receive_pin_in = optical_receive_pin_oe_n ?
    light : optical_receive_pin_out;
endmodule
`default_nettype wire

// ### bench/opc_pin_cond_chk.sv
// checker for opc_pin_cond: pin muxes and apb answer timing
// assumes bind to opc_pin_cond; config is shadowed from seen apb writes
`timescale 1ns/1ns
`default_nettype none
`include "opc_defines.svh"

module opc_pin_cond_chk
  import opc_pkg::*;
#(
  parameter int SYNC_STAGES = `OPC_SYNC_STAGES
) (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   ce,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`OPC_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pready,
  input wire logic                   tx_segment_map,
  input wire logic                   rx_segment_map,
  input wire logic                   uart_tx,
  input wire logic                   real_energy_pulse,
  input wire logic                   reactive_energy_pulse,
  input wire logic                   transmit_pin_gpio_out,
  input wire logic                   transmit_pin_gpio_oe_n,
  input wire logic                   transmit_pin_segment,
  input wire logic                   optical_transmit_pin_out,
  input wire logic                   optical_transmit_pin_oe_n,
  input wire logic                   optical_receive_pin_in,
  input wire logic                   optical_receive_pin_oe_n,
  input wire logic                   uart_rx,
  input wire logic                   receive_pin_gpio,
  input wire logic                   bitbang_uart_gpio
);
  logic [3:0] tx_cfg;
  logic [5:0] rx_cfg;
  logic [2:0] quiet;
  logic       live, seg_q, wr_ok, calm;
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && ce;
  // a map change is seen before quiet clears, so it blocks the checks too
  assign calm  = quiet == 3'h7 && seg_q == rx_segment_map;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_cfg <= 4'h0;
      rx_cfg <= 6'h00;
    end else if (wr_ok && paddr == `OPC_TX_CFG_ADDR) begin
      tx_cfg <= pwdata[3:0];
    end else if (wr_ok && paddr == `OPC_RX_CFG_ADDR) begin
      rx_cfg <= pwdata[5:0];
    end
  end
  // receive checks wait out the sync chain after any role change
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      quiet <= 3'h0;
      seg_q <= 1'b0;
      live  <= 1'b0;
    end else begin
      seg_q <= rx_segment_map;
      live  <= ce;
      if (!ce || seg_q != rx_segment_map || (wr_ok && paddr[2]))
        quiet <= 3'h0;
      else if (quiet != 3'h7)
        quiet <= quiet + 3'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_tx_seg_wins: assert property (live && $past(tx_segment_map) |->
    optical_transmit_pin_out == $past(transmit_pin_segment)
    && !optical_transmit_pin_oe_n) else $error("transmit segment lost");
  a_tx_gpio: assert property (live && !$past(tx_segment_map)
    && $past(tx_cfg[3:2]) == 2'b00 |->
    optical_transmit_pin_out == $past(transmit_pin_gpio_out)
    && optical_transmit_pin_oe_n == $past(transmit_pin_gpio_oe_n))
    else $error("transmit gpio not passed");
  a_tx_pulses: assert property (live && !$past(tx_segment_map)
    && $past(tx_cfg[3]) |-> !optical_transmit_pin_oe_n
    && optical_transmit_pin_out == ($past(tx_cfg[2]) ?
    $past(reactive_energy_pulse) : $past(real_energy_pulse)))
    else $error("pulse source wrong");
  a_tx_uart_inv: assert property (live && !$past(tx_segment_map)
    && $past(tx_cfg[3:1]) == 3'b010 |->
    optical_transmit_pin_out == ($past(uart_tx) ^ $past(tx_cfg[0])))
    else $error("uart transmit polarity wrong");
  a_tx_mod_idle: assert property (live && !$past(tx_segment_map)
    && $past(tx_cfg[3:1]) == 3'b011 && $past(uart_tx) != $past(tx_cfg[0])
    |-> optical_transmit_pin_out) else $error("carrier on high level");
  a_rx_uart: assert property (calm && !rx_segment_map
    && !rx_cfg[2] && !rx_cfg[0] |-> optical_receive_pin_oe_n && uart_rx ==
    ($past(optical_receive_pin_in, SYNC_STAGES + 1) ^ rx_cfg[1]))
    else $error("uart receive wrong");
  a_rx_gpio: assert property (calm && !rx_segment_map
    && (rx_cfg[2] || rx_cfg[0]) |-> uart_rx && receive_pin_gpio ==
    $past(optical_receive_pin_in, SYNC_STAGES + 1))
    else $error("receive gpio wrong");
  a_rx_bitbang: assert property (calm && !rx_segment_map
    && rx_cfg[0] |-> bitbang_uart_gpio ==
    $past(optical_receive_pin_in, SYNC_STAGES + 1))
    else $error("bit-bang input wrong");
  a_rx_seg_role: assert property (calm && rx_segment_map
    |-> uart_rx && !receive_pin_gpio && bitbang_uart_gpio)
    else $error("segment role leaks receive");
  a_apb_ready: assert property (psel && !penable && ce |=> pready)
    else $error("apb answer late");
  c_carrier: cover property (tx_cfg[3:1] == 3'b011 && !optical_transmit_pin_out);
  c_bitbang: cover property (quiet == 3'h7 && rx_cfg[0]);
  c_rx_seg: cover property (quiet == 3'h7 && rx_segment_map);
endmodule

bind opc_pin_cond opc_pin_cond_chk #(.SYNC_STAGES(SYNC_STAGES)) chk_u (.*);
`default_nettype wire

// ### bench/tb_opc_pin_cond.sv
// testbench for opc_pin_cond: registers, transmit mux, receive roles
// assumes the optic model closes the receive wire and shows the led
`timescale 1ns/1ns
`default_nettype none
`include "opc_defines.svh"

module tb_opc_pin_cond
  import opc_pkg::*;
;
  logic clk_sys = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [`OPC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0]  pstrb = 4'hF, txc;
  logic [5:0]  rxc;
  logic [2:0]  cdiv = 3'h0;
  logic pready, pslverr, e, glow, light = 0, carrier_ref = 0;
  logic tx_segment_map = 0, rx_segment_map = 0, uart_tx = 0;
  logic real_energy_pulse = 0, reactive_energy_pulse = 0;
  logic transmit_pin_gpio_out = 0, transmit_pin_gpio_oe_n = 1;
  logic transmit_pin_segment = 0, receive_pin_segment = 0;
  logic receive_pin_gpio_out = 0, receive_pin_gpio_oe_n = 1;
  logic optical_transmit_pin_out, optical_transmit_pin_oe_n;
  logic optical_receive_pin_in, optical_receive_pin_out;
  logic optical_receive_pin_oe_n, uart_rx, receive_pin_gpio;
  logic bitbang_uart_gpio;
  int   n_fail = 0, checks = 0, lows;

  opc_pin_cond dut_u (.*);
  opc_optic_model mdl_u (.*);

  always #50 clk_sys = ~clk_sys;
  // carrier reference rises every 8 clocks, well under clk_sys/4
  always @(posedge clk_sys) begin
    cdiv <= cdiv + 3'h1;
    carrier_ref <= cdiv[2];
  end

  task automatic close_out();
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [`OPC_ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic tx_exp(input logic [3:0] c);
    if (tx_segment_map) return transmit_pin_segment;
    case (c[3:2])
      2'b00: return transmit_pin_gpio_out;
      2'b01: return uart_tx ^ c[0];
      2'b10: return real_energy_pulse;
      default: return reactive_energy_pulse;
    endcase
  endfunction

  function automatic logic [2:0] role(input logic [5:0] c);
    if (rx_segment_map) return OPC_RX_SEG;
    return (c[2] | c[0]) ? OPC_RX_GPIO : OPC_RX_UART;
  endfunction

  // device drive wins the receive wire, else the comparator sees light
  function automatic logic rx_pin(input logic [5:0] c);
    if (rx_segment_map) return receive_pin_segment;
    if (role(c) == OPC_RX_GPIO && !receive_pin_gpio_oe_n)
      return receive_pin_gpio_out;
    return light;
  endfunction

  // comparator is inverted for the uart only, gpio sees it plain
  function automatic logic [2:0] rx_exp(input logic [5:0] c);
    return {role(c) == OPC_RX_UART ? rx_pin(c) ^ c[1] : 1'b1,
            role(c) == OPC_RX_GPIO ? rx_pin(c) : 1'b0,
            c[0] && !rx_segment_map ? rx_pin(c) : 1'b1};
  endfunction

  initial begin
    r = $urandom(32'h0149);
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, `OPC_TX_CFG_ADDR, 32'h0, r, e);
    chk(r & 32'hF, 32'h0);
    apb(1'b0, `OPC_RX_CFG_ADDR, 32'h0, r, e);
    chk(r & 32'h7FF, 32'h100);
    apb(1'b0, `OPC_TX_CFG_ADDR + 18'h10, 32'h0, r, e);
    chk({r[31:1], e}, 32'h1);
    pstrb <= 4'hE;
    apb(1'b1, `OPC_TX_CFG_ADDR, 32'hF, r, e);
    pstrb <= 4'hF;
    apb(1'b0, `OPC_TX_CFG_ADDR, 32'h0, r, e);
    chk(r & 32'hF, 32'h0);
    repeat (40) begin
      txc = 4'($urandom) & 4'hD;
      apb(1'b1, `OPC_TX_CFG_ADDR, {28'h0, txc}, r, e);
      apb(1'b0, `OPC_TX_CFG_ADDR, 32'h0, r, e);
      chk(r & 32'hF, {28'h0, txc});
      {tx_segment_map, transmit_pin_segment, transmit_pin_gpio_out, uart_tx,
       transmit_pin_gpio_oe_n, real_energy_pulse, reactive_energy_pulse}
        <= 7'($urandom);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, optical_transmit_pin_out}, {31'h0, tx_exp(txc)});
      chk({31'h0, optical_transmit_pin_oe_n},
          {31'h0, !tx_segment_map && txc[3:2] == 2'b00
                  && transmit_pin_gpio_oe_n});
    end
    repeat (30) begin
      rxc = 6'($urandom) & 6'h37;
      apb(1'b1, `OPC_RX_CFG_ADDR, {26'h0, rxc}, r, e);
      {rx_segment_map, light, receive_pin_segment, receive_pin_gpio_out,
       receive_pin_gpio_oe_n} <= 5'($urandom);
      repeat (9) @(posedge clk_sys);
      apb(1'b0, `OPC_RX_CFG_ADDR, 32'h0, r, e);
      chk(r & 32'hF37, {20'h0, rx_pin(rxc), role(rxc), 2'b00, rxc});
      chk({29'h0, uart_rx, receive_pin_gpio, bitbang_uart_gpio},
          {29'h0, rx_exp(rxc)});
    end
    apb(1'b1, `OPC_TX_CFG_ADDR, 32'h7, r, e);
    uart_tx <= 1'b1;
    tx_segment_map <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, `OPC_RX_CFG_ADDR, 32'(d) << 4, r, e);
      repeat (300) @(posedge clk_sys);
      lows = 0;
      repeat (512) begin
        @(posedge clk_sys);
        lows += int'(!glow);
      end
      chk(32'(lows), 32'd256 >> d);
    end
    apb(1'b1, `OPC_TX_CFG_ADDR, 32'h6, r, e);
    repeat (8) @(posedge clk_sys);
    chk({31'h0, glow}, 32'h1);
    // clock enable low must freeze the pin even as its source changes
    ce <= 1'b0;
    tx_segment_map <= 1'b1;
    transmit_pin_segment <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({31'h0, glow}, 32'h1);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, glow}, 32'h0);
    close_out();
  end

  // the run needs about 4100 clocks; 10000 clocks, about two and a half times that, means a hang
  initial begin
    #1000000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire

// ### verilog/opc_carrier_duty.sv
// carrier duty generator: divides carrier reference ticks into one period
// assumes tick is a one-cycle pulse on clk_sys, already synchronised
`timescale 1ns/1ns
`default_nettype none
`include "opc_defines.svh"

module opc_carrier_duty
  import opc_pkg::*;
#(
  parameter int STEPS = `OPC_CARRIER_STEPS
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic [1:0] duty_sel,
  output var  logic       carrier
);

  localparam int CW = $clog2(STEPS);

  logic [CW-1:0] count;
  logic [CW-1:0] low_len;

  // finest duty needs sixteen steps per period
  if (STEPS < 16 || (STEPS & (STEPS - 1)) != 0) begin : g_bad_steps
    $error("opc_carrier_duty: STEPS must be a power of two, at least 16");
  end

  always_comb begin
    case (duty_sel)
      OPC_DUTY_50: low_len = CW'(STEPS / 2);
      OPC_DUTY_25: low_len = CW'(STEPS / 4);
      OPC_DUTY_12: low_len = CW'(STEPS / 8);
      default:     low_len = CW'(STEPS / 16);
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (ce && tick) begin
      count <= count + 1'b1;
    end
  end

  // low part sits at the start of each period
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      carrier <= 1'b1;
    end else if (ce) begin
      carrier <= (count >= low_len);
    end
  end

endmodule

`default_nettype wire

// ### verilog/opc_defines.svh
// constants for the optical port pin conditioning block
// assumes an apb master with 32-bit data on the system clock
// Behaviour
// - map bit set gives segment, else select picks gpio/uart/real/reactive
// - transmit invert flips uart transmit before any carrier is applied
// - modulation puts the carrier out where inverted transmit is zero
// - duty field gives carrier low 50, 25, 12.5 or 6.25 percent
// - receive invert flips only the uart input, never the gpio value
// - receive disable, bit-bang enable and map bit choose uart, gpio or segment role
// - bit-bang enable presents the receive input as a gpio pin
`ifndef OPC_DEFINES_SVH
`define OPC_DEFINES_SVH

`define OPC_ADDR_W        18
`define OPC_TX_CFG_IDX    16'h2456
`define OPC_RX_CFG_IDX    16'h2457
`define OPC_TX_CFG_ADDR   ({`OPC_TX_CFG_IDX, 2'b00})
`define OPC_RX_CFG_ADDR   ({`OPC_RX_CFG_IDX, 2'b00})

`define OPC_TX_INV_BIT    0
`define OPC_TX_MOD_BIT    1
`define OPC_TX_SRC_LSB    2
`define OPC_TX_LEVEL_BIT  8

`define OPC_RX_BB_BIT     0
`define OPC_RX_INV_BIT    1
`define OPC_RX_DIS_BIT    2
`define OPC_RX_DUTY_LSB   4
`define OPC_RX_ROLE_LSB   8
`define OPC_RX_LEVEL_BIT  11

`define OPC_TX_CFG_RESET  4'h0
`define OPC_RX_CFG_RESET  6'h00

`define OPC_CARRIER_STEPS 16
`define OPC_SYNC_STAGES   2

`endif

// ### verilog/opc_pin_cond.sv
// optical port pin conditioning: apb registers, transmit and receive muxes
// assumes an apb master on clk_sys, an led driver and a receive comparator
`timescale 1ns/1ns
`default_nettype none
`include "opc_defines.svh"

module opc_pin_cond
  import opc_pkg::*;
#(
  parameter int CARRIER_STEPS = `OPC_CARRIER_STEPS,
  parameter int SYNC_STAGES   = `OPC_SYNC_STAGES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`OPC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    tx_segment_map,
  input  wire logic                    rx_segment_map,
  input  wire logic                    uart_tx,
  input  wire logic                    real_energy_pulse,
  input  wire logic                    reactive_energy_pulse,
  input  wire logic                    carrier_ref,
  input  wire logic                    transmit_pin_gpio_out,
  input  wire logic                    transmit_pin_gpio_oe_n,
  input  wire logic                    transmit_pin_segment,
  output var  logic                    optical_transmit_pin_out,
  output var  logic                    optical_transmit_pin_oe_n,
  input  wire logic                    optical_receive_pin_in,
  input  wire logic                    receive_pin_gpio_out,
  input  wire logic                    receive_pin_gpio_oe_n,
  input  wire logic                    receive_pin_segment,
  output var  logic                    optical_receive_pin_out,
  output var  logic                    optical_receive_pin_oe_n,
  output var  logic                    uart_rx,
  output var  logic                    receive_pin_gpio,
  output var  logic                    bitbang_uart_gpio
);

  // register fields
  logic        optical_tx_invert_bit;
  logic        optical_tx_modulate_bit;
  opc_tx_src_e optical_tx_source_select;
  logic        optical_bitbang_enable;
  logic        optical_rx_invert_bit;
  logic        optical_rx_disable_bit;
  logic [1:0]  carrier_duty_select;

  // bus decode
  logic        setup_phase;
  logic        write_done;
  logic        hit_tx;
  logic        hit_rx;
  logic [31:0] next_prdata;

  // synchronisers and carrier
  logic [SYNC_STAGES-1:0] rx_sync;
  logic [SYNC_STAGES-1:0] car_sync;
  logic                   car_last;
  logic                   car_tick;
  logic                   carrier;
  logic                   rx_level;

  // pin datapath
  opc_rx_role_e rx_role;
  opc_rx_role_e next_rx_role;
  logic         tx_uart_inv;
  logic         tx_uart_mod;
  logic         next_tx_out;
  logic         next_tx_oe_n;

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("opc_pin_cond: SYNC_STAGES must be at least 2");
  end

  if (CARRIER_STEPS < 16) begin : g_bad_carrier
    $error("opc_pin_cond: CARRIER_STEPS must be at least 16");
  end

  assign setup_phase = psel && !penable;
  assign write_done  = psel && penable && pready && pwrite;
  assign hit_tx      = (paddr == `OPC_TX_CFG_ADDR);
  assign hit_rx      = (paddr == `OPC_RX_CFG_ADDR);

  // read data is built in the setup cycle so that it can be registered
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_tx) begin
      next_prdata[`OPC_TX_INV_BIT] = optical_tx_invert_bit;
      next_prdata[`OPC_TX_MOD_BIT] = optical_tx_modulate_bit;
      next_prdata[`OPC_TX_SRC_LSB +: 2] = optical_tx_source_select;
      next_prdata[`OPC_TX_LEVEL_BIT] = optical_transmit_pin_out;
    end else if (hit_rx) begin
      next_prdata[`OPC_RX_BB_BIT] = optical_bitbang_enable;
      next_prdata[`OPC_RX_INV_BIT] = optical_rx_invert_bit;
      next_prdata[`OPC_RX_DIS_BIT] = optical_rx_disable_bit;
      next_prdata[`OPC_RX_DUTY_LSB +: 2] = carrier_duty_select;
      next_prdata[`OPC_RX_ROLE_LSB +: 3] = rx_role;
      next_prdata[`OPC_RX_LEVEL_BIT] = rx_level;
    end
  end

  // one wait-free access: pready rises for the first access cycle only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && setup_phase) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !(hit_tx || hit_rx);
    end
  end

  // transmit config, written only on byte lane 0
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      optical_tx_invert_bit    <= 1'(`OPC_TX_CFG_RESET >> `OPC_TX_INV_BIT);
      optical_tx_modulate_bit  <= 1'b0;
      optical_tx_source_select <= OPC_SRC_GPIO;
    end else if (ce && write_done && hit_tx && pstrb[0]) begin
      optical_tx_invert_bit    <= pwdata[`OPC_TX_INV_BIT];
      optical_tx_modulate_bit  <= pwdata[`OPC_TX_MOD_BIT];
      optical_tx_source_select <=
        opc_tx_src_e'(pwdata[`OPC_TX_SRC_LSB +: 2]);
    end
  end

  // receive config and carrier duty
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      optical_bitbang_enable <= 1'b0;
      optical_rx_invert_bit  <= 1'b0;
      optical_rx_disable_bit <= 1'b0;
      carrier_duty_select    <= OPC_DUTY_50;
    end else if (ce && write_done && hit_rx && pstrb[0]) begin
      optical_bitbang_enable <= pwdata[`OPC_RX_BB_BIT];
      optical_rx_invert_bit  <= pwdata[`OPC_RX_INV_BIT];
      optical_rx_disable_bit <= pwdata[`OPC_RX_DIS_BIT];
      carrier_duty_select    <= pwdata[`OPC_RX_DUTY_LSB +: 2];
    end
  end

  // comparator output is asynchronous to clk_sys
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_sync <= '0;
    end else if (ce) begin
      rx_sync <= {rx_sync[SYNC_STAGES-2:0], optical_receive_pin_in};
    end
  end

  assign rx_level = rx_sync[SYNC_STAGES-1];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      car_sync <= '0;
      car_last <= 1'b0;
    end else if (ce) begin
      car_sync <= {car_sync[SYNC_STAGES-2:0], carrier_ref};
      car_last <= car_sync[SYNC_STAGES-1];
    end
  end

  // carrier reference must be well below clk_sys/2 to survive sampling
  assign car_tick = car_sync[SYNC_STAGES-1] && !car_last;

  opc_carrier_duty #(
    .STEPS(CARRIER_STEPS)
  ) u_duty (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ce      (ce),
    .tick    (car_tick),
    .duty_sel(carrier_duty_select),
    .carrier (carrier)
  );

  assign tx_uart_inv = uart_tx ^ optical_tx_invert_bit;

  assign tx_uart_mod = (optical_tx_modulate_bit && !tx_uart_inv) ?
                       carrier : tx_uart_inv;

  always_comb begin
    next_tx_out  = 1'b0;
    next_tx_oe_n = 1'b0;
    if (tx_segment_map) begin
      next_tx_out = transmit_pin_segment;
    end else begin
      case (optical_tx_source_select)
        OPC_SRC_GPIO: begin
          next_tx_out  = transmit_pin_gpio_out;
          next_tx_oe_n = transmit_pin_gpio_oe_n;
        end
        OPC_SRC_UART: next_tx_out = tx_uart_mod;
        OPC_SRC_REAL: next_tx_out = real_energy_pulse;
        default:      next_tx_out = reactive_energy_pulse;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      optical_transmit_pin_out  <= 1'b0;
      optical_transmit_pin_oe_n <= 1'b1;
    end else if (ce) begin
      optical_transmit_pin_out  <= next_tx_out;
      optical_transmit_pin_oe_n <= next_tx_oe_n;
    end
  end

  always_comb begin
    if (rx_segment_map) begin
      next_rx_role = OPC_RX_SEG;
    end else if (optical_rx_disable_bit || optical_bitbang_enable) begin
      next_rx_role = OPC_RX_GPIO;
    end else begin
      next_rx_role = OPC_RX_UART;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_role <= OPC_RX_UART;
    end else if (ce) begin
      rx_role <= next_rx_role;
    end
  end

  // receive pin drive follows the role; uart role leaves it an input
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      optical_receive_pin_out  <= 1'b0;
      optical_receive_pin_oe_n <= 1'b1;
    end else if (ce) begin
      case (next_rx_role)
        OPC_RX_SEG: begin
          optical_receive_pin_out  <= receive_pin_segment;
          optical_receive_pin_oe_n <= 1'b0;
        end
        OPC_RX_GPIO: begin
          optical_receive_pin_out  <= receive_pin_gpio_out;
          optical_receive_pin_oe_n <= receive_pin_gpio_oe_n;
        end
        default: begin
          optical_receive_pin_out  <= 1'b0;
          optical_receive_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      uart_rx <= 1'b1;
    end else if (ce) begin
      uart_rx <= (next_rx_role == OPC_RX_UART) ?
                 (rx_level ^ optical_rx_invert_bit) : 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      receive_pin_gpio <= 1'b0;
    end else if (ce) begin
      receive_pin_gpio <= (next_rx_role == OPC_RX_GPIO) && rx_level;
    end
  end

  // software uart line
  // idles high when off so a firmware uart sees no false start bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bitbang_uart_gpio <= 1'b1;
    end else if (ce) begin
      bitbang_uart_gpio <= (optical_bitbang_enable &&
                            next_rx_role == OPC_RX_GPIO) ? rx_level : 1'b1;
    end
  end

endmodule

`default_nettype wire

// ### verilog/opc_pkg.sv
// types shared by the optical port pin conditioning files
// assumes opc_defines.svh is compiled alongside
package opc_pkg;

  typedef enum logic [1:0] {
    OPC_SRC_GPIO     = 2'b00,
    OPC_SRC_UART     = 2'b01,
    OPC_SRC_REAL     = 2'b10,
    OPC_SRC_REACTIVE = 2'b11
  } opc_tx_src_e;

  typedef enum logic [2:0] {
    OPC_RX_UART = 3'b001,
    OPC_RX_GPIO = 3'b010,
    OPC_RX_SEG  = 3'b100
  } opc_rx_role_e;

  typedef enum logic [1:0] {
    OPC_DUTY_50  = 2'b00,
    OPC_DUTY_25  = 2'b01,
    OPC_DUTY_12  = 2'b10,
    OPC_DUTY_6   = 2'b11
  } opc_duty_e;

endpackage
